//--- shared/fca_defines.svh
// Purpose: register map, field positions and reset values of the chunk appender
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef FCA_DEFINES_SVH
`define FCA_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define FCA_ADDR_W        8
`define FCA_OFS_CTRL      8'h00
`define FCA_OFS_CHUNK_SEL 8'h04
`define FCA_OFS_CHUNK_EN  8'h08
`define FCA_OFS_CNT_SEL   8'h0c
`define FCA_OFS_CNT_EVT   8'h10
`define FCA_OFS_CLR_ORG   8'h14
`define FCA_OFS_CLR_CMD   8'h18
`define FCA_OFS_STATUS    8'h1c
`define FCA_OFS_COUNT     8'h20

// ----------------------------------------------------------------------
// fields, sizes and reset values
// ----------------------------------------------------------------------
`define FCA_BIT_SWITCH    0
`define FCA_BIT_KIND      0
`define FCA_BIT_EXT_ON    1
`define FCA_CHUNK_COUNT   1
`define FCA_CHUNK_FRAMENUM 0
`define FCA_EXT_LAST      3'h5
`define FCA_COUNT_RESET   32'h0000_0000
`define FCA_RESP_OKAY     2'h0
`define FCA_RESP_SLVERR   2'h2

`endif

//--- shared/fca_pkg.sv
// Purpose: types shared by the chunk appender files
// Assumes: nothing
// Notes:   encodings follow declaration order
package fca_pkg;

  // ----------------------------------------------------------------------
  // configuration encodings
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FCA_CLR_OFF, FCA_CLR_INPUT_LINE_ONE, FCA_CLR_INPUT_LINE_TWO, FCA_CLR_INPUT_LINE_THREE, FCA_CLR_SOFT
  } fca_clr_origin_t;

  typedef enum logic [0:0] {FCA_CTR_FIRST, FCA_CTR_SECOND} fca_ctr_choice_t;
  typedef enum logic [0:0] {FCA_EVT_OFF, FCA_EVT_FRAME_BEGIN} fca_evt_origin_t;

  typedef enum logic [1:0] {FCA_ST_PASS, FCA_ST_EXT, FCA_ST_CNT} fca_state_t;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] offset_x;
    logic [15:0] columns;
    logic [15:0] rows;
    logic [15:0] pixel_encoding;
    logic [15:0] range_low;
    logic [15:0] range_high;
  } fca_geom_t;

  typedef struct packed {
    logic [31:0] data;
    logic        last;
  } fca_beat_t;

endpackage

//--- core/fca_line_edges.sv
// Purpose: synchronise input lines and flag each rising edge once
// Assumes: lines may be asynchronous to aclk
// Notes:   rise is a one-cycle pulse, one to two cycles after the edge
`timescale 1ns/1ps
module fca_line_edges #(
  parameter int N = 3
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [N-1:0] line_in,
  output logic      [N-1:0] rise
);
  logic [N-1:0] meta;
  logic [N-1:0] sync;
  logic [N-1:0] prev;

  // ----------------------------------------------------------------------
  // per-line synchroniser and edge detector
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_line
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta[g] <= 1'b0;
          sync[g] <= 1'b0;
          prev[g] <= 1'b0;
        end else begin
          meta[g] <= line_in[g];
          sync[g] <= meta[g];
          prev[g] <= sync[g];
        end
      end
      assign rise[g] = sync[g] & ~prev[g]; // R17
    end
  endgenerate

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_edge_once;
    @(posedge aclk) disable iff (!aresetn)
      rise[0] |=> !rise[0];
  endproperty
  a_edge_once: assert property (p_edge_once) // R17
    else $error("line edge pulse longer than one cycle");

endmodule // fca_line_edges

//--- core/frame_chunk_appender.sv
// Purpose: append extended data and frame number chunks after each image
// Assumes: image beats and frame_begin are synchronous to aclk
// Notes:   one output register stage; registers over AXI4-Lite
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fca_defines.svh"

// Functional notes
// R1: framing switch on enables the extended data chunk by itself.
// R2: per-chunk enables are writable only while the framing switch is on.
// R3: switch off clears every chunk enable, extended chunk included.
// R4: payload kind reports chunk data while switch is on, image otherwise.
// R5: extended chunk carries offset, columns, rows, pixel encoding, range low/high.
// R6: enabled frame number chunk carries the count on every completed frame.
// R7: frame count is 32 bits, starts at zero, wraps to zero.
// R8: count increases by exactly one per acquired frame.
// R9: count is zero after power-up.
// R10: stopping acquisition may leave gaps in delivered numbers.
// R11: count clear from line one, two, three, software, or disabled.
// R12: clear origin is disabled after reset.
// R13: host selects second counter with frame begin event, then clear origin.
// R14: software clear command zeroes the count when origin is software.
// R15: edge on the selected line clears the count; other lines ignored.
// R16: host picks a chunk by chunk choice, then sets its enable.
// R17: line clear acts once per synchronised rising edge.
// R18: trailer order is image, extended chunk, then enabled chunks.
module frame_chunk_appender (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [`FCA_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`FCA_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic                     frame_begin,
  input  wire fca_pkg::fca_geom_t       geom,
  input  wire logic                     input_line_one,
  input  wire logic                     input_line_two,
  input  wire logic                     input_line_three,
  input  wire logic [31:0]              img_data,
  input  wire logic                     img_last,
  input  wire logic                     img_valid,
  output logic                          img_ready,
  output fca_pkg::fca_beat_t            out_beat,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic                          payload_kind
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic                          chunk_framing_switch;
  logic [7:0]                    chunk_choice;
  logic [`FCA_CHUNK_COUNT-1:0]   per_chunk_on;
  fca_pkg::fca_ctr_choice_t      counter_choice;
  fca_pkg::fca_evt_origin_t      counter_event_origin;
  fca_pkg::fca_clr_origin_t      count_clear_origin;
  logic [31:0]                   frame_count;
  logic [31:0]                   stamped_frame_number;
  fca_pkg::fca_geom_t            stamped;
  logic                          aw_held;
  logic                          w_held;
  logic [`FCA_ADDR_W-1:0]        wr_addr;
  logic [31:0]                   wr_data;
  logic [3:0]                    wr_strb;
  logic                          do_write;
  logic                          wr_low;
  logic                          count_clear_command;
  logic                          clear_fire;
  logic [2:0]                    line_rise;
  logic [31:0]                   rd_word;
  logic                          rd_ok;
  fca_pkg::fca_state_t           st;
  logic [2:0]                    ext_idx;
  logic                          load;
  logic                          framenum_on;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] ext_word(input fca_pkg::fca_geom_t g,
                                           input logic [2:0] idx);
    logic [15:0] f;
    f = 16'h0000;
    case (idx)
      3'h0:    f = g.offset_x;
      3'h1:    f = g.columns;
      3'h2:    f = g.rows;
      3'h3:    f = g.pixel_encoding;
      3'h4:    f = g.range_low;
      default: f = g.range_high;
    endcase
    return {16'h0000, f};
  endfunction

  function automatic fca_pkg::fca_clr_origin_t to_origin(input logic [2:0] v);
    if (v <= 3'h4) begin
      return fca_pkg::fca_clr_origin_t'(v);
    end
    return fca_pkg::FCA_CLR_OFF;
  endfunction

  // ----------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  // control fields all live in byte lane 0
  assign wr_low        = do_write && wr_strb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= '0;
      wr_data      <= 32'h0000_0000;
      wr_strb      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FCA_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr <= `FCA_OFS_CLR_CMD && wr_addr[1:0] == 2'h0) ?
                        `FCA_RESP_OKAY : `FCA_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chunk_framing_switch <= 1'b0;
      chunk_choice         <= 8'h00;
      per_chunk_on         <= '0;
      counter_choice       <= fca_pkg::FCA_CTR_FIRST;
      counter_event_origin <= fca_pkg::FCA_EVT_FRAME_BEGIN;
      count_clear_origin   <= fca_pkg::FCA_CLR_OFF; // R12
    end else begin
      if (wr_low) begin
        case (wr_addr)
          `FCA_OFS_CTRL:      chunk_framing_switch <= wr_data[`FCA_BIT_SWITCH];
          `FCA_OFS_CHUNK_SEL: chunk_choice <= wr_data[7:0];
          `FCA_OFS_CHUNK_EN: begin
            for (int i = 0; i < `FCA_CHUNK_COUNT; i++) begin
              if (chunk_framing_switch && chunk_choice == 8'(i)) begin
                per_chunk_on[i] <= wr_data[0]; // R2 R16
              end
            end
          end
          `FCA_OFS_CNT_SEL:   counter_choice <= fca_pkg::fca_ctr_choice_t'(wr_data[0]);
          `FCA_OFS_CNT_EVT:   counter_event_origin <= fca_pkg::fca_evt_origin_t'(wr_data[0]);
          `FCA_OFS_CLR_ORG:   count_clear_origin <= to_origin(wr_data[2:0]); // R11 R13
          default: ;
        endcase
      end
      // switch off drops every enable, and blocks a same-cycle enable write
      if (!chunk_framing_switch) begin
        per_chunk_on <= '0; // R3
      end
    end
  end

  assign payload_kind = chunk_framing_switch; // R4
  assign framenum_on  = per_chunk_on[`FCA_CHUNK_FRAMENUM];

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      `FCA_OFS_CTRL:      rd_word[`FCA_BIT_SWITCH] = chunk_framing_switch;
      `FCA_OFS_CHUNK_SEL: rd_word[7:0] = chunk_choice;
      `FCA_OFS_CHUNK_EN: begin
        for (int i = 0; i < `FCA_CHUNK_COUNT; i++) begin
          if (chunk_choice == 8'(i)) begin
            rd_word[0] = per_chunk_on[i];
          end
        end
      end
      `FCA_OFS_CNT_SEL:   rd_word[0] = counter_choice;
      `FCA_OFS_CNT_EVT:   rd_word[0] = counter_event_origin;
      `FCA_OFS_CLR_ORG:   rd_word[2:0] = count_clear_origin;
      `FCA_OFS_CLR_CMD:   rd_word = 32'h0000_0000;
      `FCA_OFS_STATUS: begin
        rd_word[`FCA_BIT_KIND]   = payload_kind;
        rd_word[`FCA_BIT_EXT_ON] = chunk_framing_switch; // R1
      end
      `FCA_OFS_COUNT:     rd_word = frame_count;
      default:            rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `FCA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? `FCA_RESP_OKAY : `FCA_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // frame count and its clear sources
  // ----------------------------------------------------------------------
  fca_line_edges #(
    .N (3)
  ) u_edges (
    .aclk    (aclk),
    .aresetn (aresetn),
    .line_in ({input_line_three, input_line_two, input_line_one}),
    .rise    (line_rise)
  );

  assign count_clear_command = wr_low && wr_addr == `FCA_OFS_CLR_CMD && wr_data[0];

  always_comb begin
    case (count_clear_origin)
      fca_pkg::FCA_CLR_INPUT_LINE_ONE: clear_fire = line_rise[0]; // R15
      fca_pkg::FCA_CLR_INPUT_LINE_TWO: clear_fire = line_rise[1]; // R15
      fca_pkg::FCA_CLR_INPUT_LINE_THREE: clear_fire = line_rise[2]; // R15
      fca_pkg::FCA_CLR_SOFT:  clear_fire = count_clear_command; // R14
      default:                clear_fire = 1'b0;
    endcase
  end

  // clear beats a frame begin in the same cycle; that frame keeps its old stamp
  // no frame buffering here, so this side never skips a number
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_count <= `FCA_COUNT_RESET; // R9
    end else if (clear_fire) begin
      frame_count <= `FCA_COUNT_RESET; // R11
    end else if (frame_begin) begin
      frame_count <= frame_count + 32'h0000_0001; // R7 R8 R10
    end
  end

  // values are caught at frame begin so late setting changes miss this frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stamped_frame_number <= `FCA_COUNT_RESET;
      stamped              <= '0;
    end else if (frame_begin) begin
      stamped_frame_number <= frame_count; // R6
      stamped              <= geom; // R5
    end
  end

  // ----------------------------------------------------------------------
  // output stream: image, extended chunk, frame number chunk
  // ----------------------------------------------------------------------
  assign load      = !out_valid || out_ready;
  assign img_ready = (st == fca_pkg::FCA_ST_PASS) && load;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st        <= fca_pkg::FCA_ST_PASS;
      ext_idx   <= 3'h0;
      out_valid <= 1'b0;
      out_beat  <= '0;
    end else begin
      case (st)
        fca_pkg::FCA_ST_PASS: begin
          if (img_valid && img_ready) begin
            out_valid     <= 1'b1;
            out_beat.data <= img_data;
            out_beat.last <= img_last && !chunk_framing_switch;
            if (img_last && chunk_framing_switch) begin
              st      <= fca_pkg::FCA_ST_EXT; // R1 R18
              ext_idx <= 3'h0;
            end
          end else if (load) begin
            out_valid <= 1'b0;
          end
        end
        fca_pkg::FCA_ST_EXT: begin
          if (load) begin
            out_valid     <= 1'b1;
            out_beat.data <= ext_word(stamped, ext_idx); // R5
            out_beat.last <= ext_idx == `FCA_EXT_LAST && !framenum_on;
            if (ext_idx == `FCA_EXT_LAST) begin
              st <= framenum_on ? fca_pkg::FCA_ST_CNT : fca_pkg::FCA_ST_PASS; // R18
            end
            ext_idx <= ext_idx + 3'h1;
          end
        end
        fca_pkg::FCA_ST_CNT: begin
          if (load) begin
            out_valid     <= 1'b1;
            out_beat.data <= stamped_frame_number; // R6
            out_beat.last <= 1'b1;
            st            <= fca_pkg::FCA_ST_PASS;
          end
        end
        default: st <= fca_pkg::FCA_ST_PASS;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_image_end;
    img_valid && img_ready && img_last && chunk_framing_switch;
  endsequence
  sequence s_ext_start;
    st == fca_pkg::FCA_ST_EXT && ext_idx == 3'h0;
  endsequence

  property p_ext_first;
    @(posedge aclk) disable iff (!aresetn) s_image_end |=> s_ext_start;
  endproperty
  a_ext_first: assert property (p_ext_first) // R18
    else $error("extended chunk does not follow image end");

  property p_off_clears;
    @(posedge aclk) disable iff (!aresetn)
      !chunk_framing_switch |=> per_chunk_on == '0;
  endproperty
  a_off_clears: assert property (p_off_clears) // R3
    else $error("chunk enable survives switch off");

  property p_kind;
    @(posedge aclk) disable iff (!aresetn)
      wr_low && wr_addr == `FCA_OFS_CTRL
      |=> payload_kind == $past(wr_data[`FCA_BIT_SWITCH]);
  endproperty
  a_kind: assert property (p_kind) // R4
    else $error("payload kind does not follow switch");

  property p_locked_enable;
    @(posedge aclk) disable iff (!aresetn)
      (wr_low && wr_addr == `FCA_OFS_CHUNK_EN && !chunk_framing_switch)
      |=> per_chunk_on == '0;
  endproperty
  a_locked_enable: assert property (p_locked_enable) // R2
    else $error("chunk enabled while switch off");

  property p_count_step;
    @(posedge aclk) disable iff (!aresetn)
      frame_begin && !clear_fire |=> frame_count == $past(frame_count) + 32'h1;
  endproperty
  a_count_step: assert property (p_count_step) // R7 R8
    else $error("frame count did not step by one");

  property p_soft_clear;
    @(posedge aclk) disable iff (!aresetn)
      count_clear_command && count_clear_origin == fca_pkg::FCA_CLR_SOFT
      |=> frame_count == 32'h0;
  endproperty
  a_soft_clear: assert property (p_soft_clear) // R14
    else $error("software clear did not zero the count");

  property p_other_line;
    @(posedge aclk) disable iff (!aresetn)
      (line_rise[1] && count_clear_origin == fca_pkg::FCA_CLR_INPUT_LINE_ONE &&
       !line_rise[0] && !frame_begin) |=> $stable(frame_count);
  endproperty
  a_other_line: assert property (p_other_line) // R15
    else $error("unselected line changed the count");

  property p_reset_origin;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> count_clear_origin == fca_pkg::FCA_CLR_OFF && !clear_fire;
  endproperty
  a_reset_origin: assert property (p_reset_origin) // R12
    else $error("clear origin not disabled after reset");

endmodule // frame_chunk_appender

//--- verification/fca_host_sink.sv
// Purpose: host side sink for the chunk appender output stream
// Assumes: a beat is taken at the rising edge with out_valid and out_ready high
// Notes:   slow mode drops ready every other cycle
`timescale 1ns/1ps
module fca_host_sink (
  input  wire logic               aclk,
  input  wire logic               slow,
  input  wire fca_pkg::fca_beat_t out_beat,
  input  wire logic               out_valid,
  output logic                    out_ready
);
  fca_pkg::fca_beat_t got[$];

  initial out_ready = 1'b1;
  always @(posedge aclk) out_ready <= slow ? ~out_ready : 1'b1;
  // sampled mid-cycle: stable until the taking edge, so no race with the design
  always @(negedge aclk) if (out_valid && out_ready) got.push_back(out_beat);
endmodule // fca_host_sink

//--- verification/frame_chunk_appender_tb.sv
// Purpose: register and stream tests of the chunk appender
// Assumes: AXI4-Lite master tasks, host sink model on the output
// Notes:   counter wrap is not reached in a run of this length
`timescale 1ns/1ps
`include "fca_defines.svh"
module frame_chunk_appender_tb;
  logic               aclk = 0, aresetn = 0, frame_begin = 0, slow = 0;
  logic               awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic               img_valid = 0, img_last = 0;
  logic               awready, wready, bvalid, arready, rvalid, img_ready, out_valid, out_ready;
  logic               payload_kind;
  logic [2:0]         lines = 0;
  logic [7:0]         awaddr = 0, araddr = 0;
  logic [31:0]        wdata = 0, img_data = 0, rdata, got, exp_cnt = 0;
  logic [1:0]         bresp, rresp, resp;
  int                 errors = 0, check_count = 0;
  fca_pkg::fca_geom_t geom = {16'h0010, 16'h0040, 16'h0003, 16'h0108, 16'h0002, 16'h0fff};
  fca_pkg::fca_beat_t out_beat;

  initial forever #5 aclk = ~aclk;

  frame_chunk_appender dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .frame_begin(frame_begin), .geom(geom), .input_line_one(lines[0]),
    .input_line_two(lines[1]), .input_line_three(lines[2]), .img_data(img_data),
    .img_last(img_last), .img_valid(img_valid), .img_ready(img_ready), .out_beat(out_beat),
    .out_valid(out_valid), .out_ready(out_ready), .payload_kind(payload_kind));

  fca_host_sink host (.aclk(aclk), .slow(slow), .out_beat(out_beat), .out_valid(out_valid),
    .out_ready(out_ready));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic finish_test;
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // handshakes judged at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    rd(a);
    chk(n, e, got);
  endtask

  task automatic bump;
    @(posedge aclk);
    frame_begin <= 1'b1;
    @(posedge aclk);
    frame_begin <= 1'b0;
    exp_cnt++;
  endtask

  // frame counted while the line is still high: a held line must not clear again
  task automatic pulse(input int k, input bit clr);
    @(posedge aclk);
    lines <= lines | (3'h1 << k);
    repeat (6) @(posedge aclk);
    if (clr) exp_cnt = 0;
    bump();
    lines <= lines & ~(3'h1 << k);
    rc(`FCA_OFS_COUNT, exp_cnt, "count");
  endtask

  task automatic frame(input int n, input bit trail, input bit stamp);
    fca_pkg::fca_beat_t e[$];
    logic t;
    int w;
    for (int i = 0; i < n; i++) e.push_back({32'h100 + i, !trail && i == n - 1});
    if (trail) begin
      for (int i = 5; i >= 0; i--) e.push_back({16'h0, geom[16*i +: 16], !stamp && i == 0});
      if (stamp) e.push_back({exp_cnt, 1'b1});
    end
    host.got.delete();
    bump();
    for (int i = 0; i < n; i++) begin
      img_data <= 32'h100 + i;
      img_last <= (i == n - 1);
      img_valid <= 1'b1;
      do begin
        @(negedge aclk);
        t = img_ready;
        @(posedge aclk);
      end while (!t);
    end
    img_valid <= 1'b0;
    img_last <= 1'b0;
    w = 0;
    while (host.got.size() < e.size() && w < 300) begin
      @(posedge aclk);
      w++;
    end
    chk("beat count", e.size(), host.got.size());
    foreach (e[i]) if (i < host.got.size()) chk("beat", e[i], host.got[i]);
  endtask

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`FCA_OFS_CLR_ORG, 0, "clear origin");
    rc(`FCA_OFS_COUNT, 0, "count");
    chk("payload kind", 0, payload_kind);
    wr(`FCA_OFS_CHUNK_EN, 1);
    rc(`FCA_OFS_CHUNK_EN, 0, "chunk on");
    wr(`FCA_OFS_CTRL, 1);
    chk("payload kind", 1, payload_kind);
    rc(`FCA_OFS_STATUS, 3, "status");
    wr(`FCA_OFS_CHUNK_SEL, 0);
    wr(`FCA_OFS_CHUNK_EN, 1);
    rc(`FCA_OFS_CHUNK_EN, 1, "chunk on");
    slow <= 1'b1;
    frame(2, 1, 1);
    slow <= 1'b0;
    frame(1, 1, 1);
    rc(`FCA_OFS_COUNT, exp_cnt, "count");
    wr(`FCA_OFS_CNT_SEL, 1);
    wr(`FCA_OFS_CNT_EVT, 1);
    for (int k = 0; k < 3; k++) begin
      wr(`FCA_OFS_CLR_ORG, k + 1);
      pulse((k + 1) % 3, 0);
      pulse(k, 1);
    end
    wr(`FCA_OFS_CLR_ORG, 4);
    wr(`FCA_OFS_CLR_CMD, 1);
    exp_cnt = 0;
    rc(`FCA_OFS_COUNT, 0, "count");
    bump();
    wr(`FCA_OFS_CLR_ORG, 0);
    for (int k = 0; k < 3; k++) pulse(k, 0);
    wr(`FCA_OFS_CLR_CMD, 1);
    rc(`FCA_OFS_COUNT, exp_cnt, "count");
    rd(8'h24);
    chk("read resp", `FCA_RESP_SLVERR, resp);
    wr(`FCA_OFS_STATUS, 0);
    chk("write resp", `FCA_RESP_SLVERR, resp);
    wr(`FCA_OFS_CTRL, 0);
    rc(`FCA_OFS_CHUNK_EN, 0, "chunk on");
    chk("payload kind", 0, payload_kind);
    frame(2, 0, 0);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    finish_test();
  end
endmodule // frame_chunk_appender_tb
